// >>> pit_timer_top.sv
`timescale 1ns/10ps
`default_nettype none

module pit_timer_top
  import pit_pkg::*;
(
  // clock and reset
  input  wire  logic                  clk,
  input  wire  logic                  nrst,
  // apb slave
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [7:0]            paddr,
  input  wire  logic [31:0]           pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // device state and pins
  input  wire  logic                  idle_mode,
  input  wire  logic [NUM_TIMERS-1:0] external_timer_clock_pin,
  input  wire  logic [NUM_TIMERS-1:0] gate_pin,
  // interrupt
  output logic                        irq
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode; zero wait state, every access completes in its access
  // phase
  wire       acc   = psel && penable;
  wire       wr    = acc && pwrite;
  wire [1:0] tsel  = paddr[5:4];
  wire       in_t  = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
  wire [7:0] roff  = {4'h0, paddr[3:0]};
  wire       hit_ctl = in_t && (roff == OFS_CTL);
  wire       hit_cnt = in_t && (roff == OFS_CNT);
  wire       hit_per = in_t && (roff == OFS_PER);
  wire       hit_st  = (paddr == OFS_IRQ_STAT);
  wire       hit_en  = (paddr == OFS_IRQ_EN);
  wire       hit_clr = (paddr == OFS_IRQ_CLR);
  wire       mapped  = hit_ctl || hit_cnt || hit_per || hit_st ||
                       hit_en || hit_clr;

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0]           ctl_r  [NUM_TIMERS];
  logic [15:0]           cnt_r  [NUM_TIMERS];
  logic [15:0]           per_r  [NUM_TIMERS];
  logic [15:0]           cnt_nxt[NUM_TIMERS];
  logic [NUM_TIMERS-1:0] stat_r;
  logic [NUM_TIMERS-1:0] en_r;
  logic [NUM_TIMERS-1:0] ev;
  logic [NUM_TIMERS-1:0] ext_s;
  logic [NUM_TIMERS-1:0] gate_s;
  logic [NUM_TIMERS-1:0] ext_d_r;
  logic [NUM_TIMERS-1:0] gate_d_r;
  logic [NUM_TIMERS-1:0] ps_tick;
  logic [NUM_TIMERS-1:0] run;

  // two-flop synchronisers for the clock and gate pins
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++)
    begin : g_pin
      pit_sync u_ext (.clk(clk), .nrst(nrst),
                      .din(external_timer_clock_pin[g]),
                      .dout(ext_s[g]));
      pit_sync u_gate (.clk(clk), .nrst(nrst),
                       .din(gate_pin[g]), .dout(gate_s[g]));
    end
  endgenerate

  // edge history of synchronised pins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_d_r  <= '0;
      gate_d_r <= '0;
    end
    else
    begin
      ext_d_r  <= ext_s;
      gate_d_r <= gate_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // effective settings: an odd timer in a pair borrows its even
  // partner's enable, gate, prescale and source
  logic [NUM_TIMERS-1:0] pair;
  logic [NUM_TIMERS-1:0] on_e;
  logic [NUM_TIMERS-1:0] cs_e;
  logic [NUM_TIMERS-1:0] gate_e;
  logic [NUM_TIMERS-1:0] src;
  logic [2:0]            ps_e[NUM_TIMERS];

  generate
    for (g = 0; g < NUM_TIMERS; g++)
    begin : g_cfg
      localparam int M = g & ~1;   // even member of the pair
      // pairs are timer 2/3 and 4/5, i.e. index 0/1 and 2/3
      assign pair[g]  = ctl_r[M][CTL_PAIR_BIT];
      assign on_e[g]  = ctl_r[(pair[g]) ? M : g][CTL_ON_BIT];
      assign cs_e[g]  = ctl_r[(pair[g]) ? M : g][CTL_CS_BIT];
      assign ps_e[g]  = ctl_r[(pair[g]) ? M : g][6:4];
      assign gate_e[g] = ctl_r[(pair[g]) ? M : g][CTL_GATE_BIT]
                         && !cs_e[g];
      // a pair halts in idle when either half has stop-in-idle set, so
      // software must clear both to keep the 32-bit timer running
      wire idle_stop = pair[g] ? (ctl_r[M][CTL_STOP_IN_IDLE_BIT] ||
                                  ctl_r[M+1][CTL_STOP_IN_IDLE_BIT])
                               : ctl_r[g][CTL_STOP_IN_IDLE_BIT];
      assign run[g] = on_e[g] && !(idle_mode && idle_stop);
      // pins follow the settings: own pins alone, even's pins in a pair
      wire ext_rise = pair[g] ? (ext_s[M] && !ext_d_r[M])
                              : (ext_s[g] && !ext_d_r[g]);
      wire gate_lvl = pair[g] ? gate_s[M] : gate_s[g];
      // source edge: peripheral clock every cycle the gate allows (gate high, or gating off), or a pin rise
      assign src[g] = cs_e[g] ? ext_rise
                              : (!gate_e[g] || gate_lvl);
      pit_prescaler u_ps (.clk(clk), .nrst(nrst), .clr(!run[g]),
                          .src_tick(run[g] && src[g]),
                          .sel(ps_e[g]), .tick(ps_tick[g]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // counting: 16-bit by default, 32-bit when paired, high half in odd
  always_comb
  begin
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      cnt_nxt[i]  = cnt_r[i];
      ev[i]       = 1'b0;
    end
    for (int i = 0; i < NUM_TIMERS; i += 2)
    begin
      if (pair[i])
      begin
        // even timer's prescaler drives the whole 32-bit count
        if (ps_tick[i])
        begin
          if ({cnt_r[i+1], cnt_r[i]} == {per_r[i+1], per_r[i]})
          begin
            cnt_nxt[i]   = CNT_RESET;
            cnt_nxt[i+1] = CNT_RESET;
            ev[i+1]      = 1'b1;
          end
          else
          begin
            {cnt_nxt[i+1], cnt_nxt[i]} =
              {cnt_r[i+1], cnt_r[i]} + 32'h0000_0001;
          end
        end
        if (gate_e[i] && gate_d_r[i] && !gate_s[i] && run[i])
          ev[i+1] = 1'b1;
      end
      else
      begin
        for (int k = i; k < i + 2; k++)
        begin
          // independent 16-bit timers
          if (ps_tick[k])
          begin
            if (cnt_r[k] == per_r[k])
            begin
              cnt_nxt[k] = CNT_RESET;
              ev[k]      = 1'b1;
            end
            else
              cnt_nxt[k] = cnt_r[k] + 16'h0001;
          end
          if (gate_e[k] && gate_d_r[k] && !gate_s[k] && run[k])
            ev[k] = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes; the write mask drops unimplemented bits
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        ctl_r[i] <= CTL_RESET;
        cnt_r[i] <= CNT_RESET;
        per_r[i] <= PER_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        cnt_r[i] <= cnt_nxt[i];
        if (wr && hit_ctl && tsel == i[1:0])
          ctl_r[i] <= pwdata & ((i % 2 == 0) ? CTL_MASK_EVEN
                                             : CTL_MASK_ODD);
        if (wr && hit_cnt && tsel == i[1:0])
          cnt_r[i] <= pwdata[15:0];   // software write beats the tick
        if (wr && hit_per && tsel == i[1:0])
          per_r[i] <= pwdata[15:0];
      end
    end
  end

  // interrupt status: set wins over a clear in the same cycle
  wire [NUM_TIMERS-1:0] clr_bits = (wr && hit_clr) ?
                                   pwdata[NUM_TIMERS-1:0] : '0;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_r <= '0;
      en_r   <= '0;
    end
    else
    begin
      stat_r <= (stat_r & ~clr_bits) | ev;
      if (wr && hit_en)
        en_r <= pwdata[NUM_TIMERS-1:0];
    end
  end

  assign irq = |(stat_r & en_r);

  ////////////////////////////////////////////////////////////////////////
  // read mux; gate bit reads zero while the external source is chosen
  wire [31:0] ctl_rd = ctl_r[tsel] &
                       ~(ctl_r[tsel][CTL_CS_BIT] ? 32'h0000_0080
                                                 : 32'h0000_0000);
  wire [31:0] rd_mux =
      hit_ctl ? ctl_rd :
      hit_cnt ? {16'h0000, cnt_r[tsel]} :
      hit_per ? {16'h0000, per_r[tsel]} :
      hit_st  ? {28'h0000000, stat_r} :
      hit_en  ? {28'h0000000, en_r} : 32'h0000_0000;

  assign prdata = (acc && !pwrite) ? rd_mux : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // checks
  wrap_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    (!pair[0] && ps_tick[0] && cnt_r[0] == per_r[0] &&
     !(wr && hit_cnt && tsel == 2'd0))
    |=> (cnt_r[0] == 16'h0000) && stat_r[0])
    else $error("timer 0 did not wrap and flag at period");
  off_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (!on_e[0] && !(wr && hit_cnt)) |=> $stable(cnt_r[0]))
    else $error("disabled timer 0 changed its count");
  idle_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (idle_mode && ctl_r[0][CTL_STOP_IN_IDLE_BIT]) |-> !ps_tick[0])
    else $error("timer 0 ticked in idle with stop-in-idle set");
  gate_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (acc && !pwrite && hit_ctl && ctl_r[tsel][CTL_CS_BIT])
    |-> !prdata[CTL_GATE_BIT])
    else $error("gate bit read as one with external clock");
  odd_pair_a: assert property (@(posedge clk) disable iff (!nrst)
    ctl_r[1][CTL_PAIR_BIT] == 1'b0 && ctl_r[3][CTL_PAIR_BIT] == 1'b0)
    else $error("pairing bit stored in an odd timer");
  unimpl_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctl_r[0] & ~CTL_MASK_EVEN) == 32'h0000_0000)
    else $error("unimplemented control bit stored");
  pair_carry_a: assert property (@(posedge clk) disable iff (!nrst)
    (pair[0] && ps_tick[0] && cnt_r[0] == 16'hffff &&
     {cnt_r[1], cnt_r[0]} != {per_r[1], per_r[0]} && !(wr && hit_cnt))
    |=> cnt_r[1] == $past(cnt_r[1]) + 16'h0001)
    else $error("paired timer missed carry into odd half");
  gate_fall_a: assert property (@(posedge clk) disable iff (!nrst)
    (!pair[0] && gate_e[0] && run[0] && gate_d_r[0] && !gate_s[0])
    |=> stat_r[0])
    else $error("gate falling edge did not flag timer 0");
  irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
    (ev[0] && en_r[0] && !(wr && hit_en)) |=> irq)
    else $error("enabled timer 0 event did not raise the interrupt");

endmodule : pit_timer_top

`default_nettype wire

// >>> pit_pkg.sv
package pit_pkg;

  // timer population: timers 2..5, index 0..3 inside this block
  localparam int          NUM_TIMERS   = 4;
  localparam int          CNT_W        = 16;

  // control register field positions
  localparam int          CTL_ON_BIT   = 15;
  localparam int          CTL_STOP_IN_IDLE_BIT = 13;
  localparam int          CTL_GATE_BIT = 7;
  localparam int          CTL_PS_LSB   = 4;
  localparam int          CTL_PAIR_BIT = 3;
  localparam int          CTL_CS_BIT   = 1;
  localparam logic [31:0] CTL_MASK_EVEN = 32'h0000_a0fa;
  localparam logic [31:0] CTL_MASK_ODD  = 32'h0000_a0f2;
  localparam logic [31:0] CTL_RESET     = 32'h0000_0000;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] PER_RESET     = 16'hffff;

  // register map: per timer a 16-byte stride, shared registers above
  localparam logic [7:0] OFS_CTL      = 8'h00;
  localparam logic [7:0] OFS_CNT      = 8'h04;
  localparam logic [7:0] OFS_PER      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h44;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h48;

  // prescale step: divide ratio minus one for each select code
  function automatic logic [7:0] pit_ps_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    pit_ps_limit = 8'h00;
      3'h1:    pit_ps_limit = 8'h01;
      3'h2:    pit_ps_limit = 8'h03;
      3'h3:    pit_ps_limit = 8'h07;
      3'h4:    pit_ps_limit = 8'h0f;
      3'h5:    pit_ps_limit = 8'h1f;
      3'h6:    pit_ps_limit = 8'h3f;
      default: pit_ps_limit = 8'hff;
    endcase
  endfunction : pit_ps_limit

endpackage : pit_pkg

// >>> pit_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pit_sync
  import pit_pkg::*;
(
  // clock and reset
  input  wire  logic clk,
  input  wire  logic nrst,
  // asynchronous level in, synchronised level out
  input  wire  logic din,
  output logic       dout
);

  logic meta_r;

  // two-stage synchroniser; meta_r feeds only the second stage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : pit_sync

`default_nettype wire

// >>> pit_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module pit_prescaler
  import pit_pkg::*;
(
  // clock and reset
  input  wire  logic       clk,
  input  wire  logic       nrst,
  // control
  input  wire  logic       clr,
  input  wire  logic       src_tick,
  input  wire  logic [2:0] sel,
  // output one-cycle enable
  output logic             tick
);

  logic [7:0] div_r;
  wire  [7:0] limit = pit_ps_limit(sel);
  wire        wrap  = src_tick && (div_r >= limit);

  assign tick = wrap;

  // divider restarts when the timer stops so the first tick is a full one
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_r <= 8'h00;
    else if (clr || wrap)
      div_r <= 8'h00;
    else if (src_tick)
      div_r <= div_r + 8'h01;
  end

endmodule : pit_prescaler

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import pit_pkg::*;
();
  // bench signals
  logic                  clk;
  logic                  nrst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  idle_mode;
  logic [NUM_TIMERS-1:0] ext_pin;
  logic [NUM_TIMERS-1:0] gate;
  logic                  irq;
  logic [31:0]           rd;
  logic                  er;
  logic [31:0]           v;
  int                    n_mismatch;
  int                    checks_done;
  int                    cyc;
  int                    seed;
  int                    i;
  int                    ps_div [8] = '{1, 2, 4, 8, 16, 32, 64, 256};

  pit_timer_top dut_u (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
    .external_timer_clock_pin(ext_pin), .gate_pin(gate), .irq(irq)
  );

  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard; total run is a few thousand cycles
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb master: request held until the rising edge that samples pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk); // idle edge before every setup
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  // counts near a clock boundary may land one tick either way
  task automatic rng(input string nm, input logic [31:0] lo,
                     input logic [31:0] hi, input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    checks_done++;
    if ((rd >= lo && rd <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h..%h seen %h", nm, lo, hi, rd);
    end
  endtask : rng

  // control readback: dropped positions, gate hidden under external source
  function automatic logic [31:0] exp_ctl(input int t, input logic [31:0] d);
    logic [31:0] r;
    r = d & ((t % 2 == 0) ? CTL_MASK_EVEN : CTL_MASK_ODD);
    if (r[CTL_CS_BIT])
      r[CTL_GATE_BIT] = 1'b0;
    return r;
  endfunction : exp_ctl

  task final_report;
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {nrst, psel, penable, pwrite, idle_mode} = 5'h00;
    {paddr, pwdata, ext_pin, gate} = 48'h0;
    {n_mismatch, checks_done, cyc} = 0;
    seed = 32'h84ae660f;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int t = 0; t < 4; t++)
    begin
      rdc("ctl_reset", 8'h10 * t, 32'h0);
      rdc("count_reset", 8'h10 * t + 8'h04, 32'h0);
      rdc("period_reset", 8'h10 * t + 8'h08, 32'hffff);
    end
    rdc("status_reset", OFS_IRQ_STAT, 32'h0);
    chk("irq_reset", {31'h0, irq}, 32'h0);
    // all-ones corner first, then random control and count words
    for (int k = 0; k < 16; k++)
    begin
      v = (k < 4) ? 32'hffffffff : $random(seed);
      i = (k < 4) ? k : {$random(seed)} % 4;
      wr(8'h10 * i, v);
      rdc("ctl_readback", 8'h10 * i, exp_ctl(i, v));
      wr(8'h10 * i, 32'h0);
      v = $random(seed);
      wr(8'h10 * i + 8'h04, v);
      rdc("count_readback", 8'h10 * i + 8'h04, v & 32'hffff);
    end
    wr(OFS_IRQ_CLR, 32'hf);
    // every prescale code, four ticks each
    for (int p = 0; p < 8; p++)
    begin
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h8000 | (p << CTL_PS_LSB));
      repeat (4 * ps_div[p] - 2) @(posedge clk);
      wr(8'h00, 32'h0);
      rng("count_prescaled", 3, 5, 8'h04);
    end
    v = rd;
    repeat (20) @(posedge clk);
    rdc("count_held_off", 8'h04, v);
    // period wrap, sticky flag, mask and clear
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h0);
    wr(OFS_IRQ_EN, 32'h1);
    wr(8'h00, 32'h8000);
    repeat (10) @(posedge clk);
    wr(8'h00, 32'h0);
    rdc("status_wrap", OFS_IRQ_STAT, 32'h1);
    rng("count_wrapped", 0, 3, 8'h04);
    chk("irq_enabled", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_EN, 32'h0);
    @(negedge clk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_CLR, 32'h1);
    rdc("status_cleared", OFS_IRQ_STAT, 32'h0);
    rdc("clear_reads_zero", OFS_IRQ_CLR, 32'h0);
    wr(8'h08, 32'hffff);
    apb(1'b0, 8'h30 + 8'h0c, 32'h0);
    chk("slverr_unmapped", {31'h0, er}, 32'h1);
    chk("prdata_unmapped", rd, 32'h0);
    // gated accumulation on timer index 1
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h8080);
    repeat (10) @(posedge clk);
    rdc("count_gate_low", 8'h14, 32'h0);
    gate[1] <= 1'b1;
    repeat (10) @(posedge clk);
    gate[1] <= 1'b0;
    repeat (8) @(posedge clk);
    wr(8'h10, 32'h0);
    rng("count_gated", 9, 11, 8'h14);
    rdc("status_gate_fall", OFS_IRQ_STAT, 32'h2);
    // external pin on timer index 3, gate bit set but ignored
    wr(8'h34, 32'h0);
    wr(8'h30, 32'h8082);
    rdc("ctl_gate_hidden", 8'h30, 32'h8002);
    repeat (5)
    begin
      ext_pin[3] <= 1'b1;
      repeat (4) @(posedge clk);
      ext_pin[3] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    wr(8'h30, 32'h0);
    rdc("count_external", 8'h34, 32'h5);
    // stop-in-idle on timer index 2
    idle_mode <= 1'b1;
    wr(8'h24, 32'h0);
    wr(8'h20, 32'ha000);
    repeat (10) @(posedge clk);
    rdc("count_idle_halt", 8'h24, 32'h0);
    wr(8'h20, 32'h8000);
    repeat (10) @(posedge clk);
    wr(8'h20, 32'h0);
    rng("count_idle_run", 10, 14, 8'h24);
    idle_mode <= 1'b0;
    // both pairs: separate, then joined with odd settings inert
    for (int p = 0; p < 4; p += 2)
    begin
      wr(8'h10 * p + 8'h04, 32'hfffe);
      wr(8'h10 * p + 8'h14, 32'h0);
      wr(8'h10 * p + 8'h18, 32'hffff);
      wr(8'h10 * p, 32'h8000);
      repeat (4) @(posedge clk);
      wr(8'h10 * p, 32'h0);
      rdc("odd_unpaired", 8'h10 * p + 8'h14, 32'h0);
      wr(8'h10 * p + 8'h04, 32'hfffe);
      wr(8'h10 * p + 8'h10, 32'h8002);
      wr(8'h10 * p, 32'h8008);
      repeat (4) @(posedge clk);
      wr(8'h10 * p, 32'h0);
      wr(8'h10 * p + 8'h10, 32'h0);
      rdc("odd_carry", 8'h10 * p + 8'h14, 32'h1);
    end
    // pair in idle: the odd half's stop-in-idle bit alone halts it
    idle_mode <= 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h2000);
    wr(8'h00, 32'h8008);
    repeat (10) @(posedge clk);
    rdc("pair_idle_halt", 8'h04, 32'h0);
    wr(8'h10, 32'h0);
    repeat (10) @(posedge clk);
    wr(8'h00, 32'h0);
    rng("pair_idle_run", 10, 14, 8'h04);
    idle_mode <= 1'b0;
    final_report();
  end

endmodule : tb_top

`default_nettype wire
